// [bench/lmu_checker_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the decoder ports for flag, strobe and length behaviour.
module lmu_checker (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       ce,
  input wire logic       instr_valid,
  input wire logic       instr_ready,
  input wire logic [7:0] instr_b0,
  input wire logic       rf_we,
  input wire logic [7:0] rf_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic       pm_rd,
  input wire logic       pm_wr,
  input wire logic       dm_rd,
  input wire logic       dm_wr,
  input wire logic       flags_we,
  input wire logic       instr_done,
  input wire logic [2:0] instr_bytes,
  input wire logic       bad_opcode,
  input wire logic       pm_write_blocked
);
  logic acc;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // An instruction is taken at this edge.
  assign acc = instr_valid && instr_ready && ce;
  // Relations between requests, strobes and completion.
  AST_NO_FLAGS: assert property (!flags_we)
    else $error("flag write seen");
  AST_ONE_SPACE: assert property ($onehot0({pm_rd, pm_wr, dm_rd, dm_wr, pm_write_blocked}))
    else $error("two memory strobes at once");
  AST_STORE_NO_RF: assert property ((pm_wr || dm_wr || pm_write_blocked) |-> !rf_we)
    else $error("register write during store");
  AST_BAD_LEN: assert property (bad_opcode |-> instr_done && instr_bytes == 3'h1)
    else $error("bad opcode length wrong");
  AST_ACCEPT: assert property (acc |=> !instr_ready)
    else $error("ready after accept");
  AST_E4_LEN: assert property (acc && instr_b0 == 8'hE4 ##1 (ce && !instr_done) [*5]
    |=> instr_done && instr_bytes == 3'h3)
    else $error("register move length wrong");
  AST_COMPACT_LEN: assert property (acc && instr_b0[3:0] == 4'hC ##1 (ce && !instr_done) [*3]
    |=> instr_done && instr_bytes == 3'h2)
    else $error("compact move length wrong");
  AST_LOAD_DATA: assert property ((pm_rd || dm_rd) && ce ##1 ce
    |=> rf_we && rf_wdata == $past(mem_rdata))
    else $error("loaded byte not written");
endmodule // lmu_checker

bind load_move_instruction_unit lmu_checker i_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
  .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_b0(instr_b0), .rf_we(rf_we),
  .rf_wdata(rf_wdata), .mem_rdata(mem_rdata), .pm_rd(pm_rd), .pm_wr(pm_wr), .dm_rd(dm_rd),
  .dm_wr(dm_wr), .flags_we(flags_we), .instr_done(instr_done), .instr_bytes(instr_bytes),
  .bad_opcode(bad_opcode), .pm_write_blocked(pm_write_blocked));
`default_nettype wire

// [bench/mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Program and data memory; read data follows a read strobe by one cycle.
module mem_model (
  input  wire logic        clock,
  input  wire logic        pm_rd,
  input  wire logic        pm_wr,
  input  wire logic        dm_rd,
  input  wire logic        dm_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata
);
  logic [7:0] pm [65536];
  logic [7:0] dm [65536];
  // Each space starts with its own pattern so a wrong space shows.
  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      pm[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
      dm[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
  end
  // Undriven read data toggles so a sample one cycle late never matches.
  always @(posedge clock) begin
    if (pm_wr) pm[mem_addr] <= mem_wdata;
    if (dm_wr) dm[mem_addr] <= mem_wdata;
    if (pm_rd) mem_rdata <= pm[mem_addr];
    else if (dm_rd) mem_rdata <= dm[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule // mem_model
`default_nettype wire

// [bench/tb_load_move_instruction_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
// Queues expected writes per instruction and compares them as they appear.
module tb_load_move_instruction_unit;
  logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b0, ce_rand = 1'b0;
  logic        instr_valid = 1'b0, rom_masked = 1'b0;
  logic [3:0]  wr_base = 4'h2;
  logic [7:0]  instr_b0 = 8'h00, instr_b1 = 8'h00, instr_b2 = 8'h00, instr_b3 = 8'h00;
  logic [7:0]  rf [256];
  logic [25:0] exp_q [$];
  int          fail_count = 0, num_checks = 0, cyc = 0;
  wire         instr_ready, rf_we, pm_rd, pm_wr, dm_rd, dm_wr, flags_we;
  wire         instr_done, bad_opcode, pm_write_blocked;
  wire [2:0]   instr_bytes;
  wire [7:0]   rf_raddr, rf_rdata, rf_waddr, rf_wdata, mem_wdata, mem_rdata;
  wire [15:0]  mem_addr;
  load_move_instruction_unit i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_b0(instr_b0),
    .instr_b1(instr_b1), .instr_b2(instr_b2), .instr_b3(instr_b3), .wr_base(wr_base),
    .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .pm_rd(pm_rd), .pm_wr(pm_wr), .dm_rd(dm_rd), .dm_wr(dm_wr), .flags_we(flags_we),
    .rom_masked(rom_masked), .instr_done(instr_done), .instr_bytes(instr_bytes),
    .bad_opcode(bad_opcode), .pm_write_blocked(pm_write_blocked));
  mem_model i_mem (.clock(clock), .pm_rd(pm_rd), .pm_wr(pm_wr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Register file with a combinational read port.
  assign rf_rdata = rf[rf_raddr];
  always @(posedge clock) if (rf_we) rf[rf_waddr] <= rf_wdata;
  initial forever #2 clock = ~clock;
  // Optional random clock enable stretches instructions.
  always @(posedge clock) if (ce_rand) ce <= ($urandom % 4) != 0;
  function automatic [7:0] w(input [3:0] n);
    w = {wr_base, n};
  endfunction
  task automatic push(input [2:0] k, input [15:0] a, input [7:0] d);
    exp_q.push_back({k, a, d});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic take(input [25:0] got);
    logic [25:0] e;
    if (exp_q.size() == 0) begin
      fail_count++;
      $display("[ERR] %0t unexpected result %h", $time, got);
    end else begin
      // Pop once, so a mismatch report does not eat the next note.
      e = exp_q.pop_front();
      `CHK(got, e)
    end
  endtask
  // Issues one instruction and checks its length in cycles and bytes.
  task automatic run(input [31:0] ins, input int n, input [2:0] nb);
    int k;
    @(posedge clock);
    instr_valid <= 1'b1;
    {instr_b3, instr_b2, instr_b1, instr_b0} <= ins;
    do @(negedge clock); while (!(instr_ready === 1'b1 && ce === 1'b1));
    @(posedge clock);
    instr_valid <= 1'b0;
    k = 1;
    forever begin
      @(negedge clock);
      if (instr_done === 1'b1) break;
      if (ce === 1'b1) k++;
    end
    `CHK(k, n)
    `CHK(instr_bytes, nb)
    `CHK(bad_opcode, n == 1)
  endtask
  // Memory transfer with its address strobe and resulting write.
  task automatic mem(input [7:0] op, b1, b2, b3, input [15:0] a, input int n);
    logic st;
    st = (op == 8'hD3 || op == 8'hF7 || op == 8'hB7);
    if (!st) begin
      push(b1[0] ? 3'd5 : 3'd4, a, 8'h00);
      push(3'd0, w(b1[7:4]), a[7:0] ^ a[15:8] ^ (b1[0] ? 8'hA5 : 8'h5A));
    end else push(b1[0] ? 3'd2 : (rom_masked ? 3'd3 : 3'd1), a, rf[w(b1[7:4])]);
    run({b3, b2, b1, op}, n, n == 10 ? 3'h2 : (n == 12 ? 3'h3 : 3'h4));
  endtask
  // Every strobe cycle that advances is one result.
  always @(negedge clock) begin
    if (rst_n && ce) begin
      if (rf_we) take({3'd0, 8'h00, rf_waddr, rf_wdata});
      if (pm_rd) take({3'd4, mem_addr, 8'h00});
      if (dm_rd) take({3'd5, mem_addr, 8'h00});
      if (pm_wr) take({3'd1, mem_addr, mem_wdata});
      if (dm_wr) take({3'd2, mem_addr, mem_wdata});
      if (pm_write_blocked) take({3'd3, mem_addr, mem_wdata});
    end
  end
  // Guard against a hang.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end
  // Main sequence.
  initial begin
    logic [7:0] d, s;
    logic [2:0] b;
    void'($urandom(32'hCDA8EA12));
    for (int i = 0; i < 256; i++) rf[i] = $urandom;
    rf[w(6)] = 8'h50;
    rf[8'h47] = 8'h48;
    {rf[w(2)], rf[w(3)], rf[w(4)], rf[w(5)]} = 32'h1234FFF8;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    ce <= 1'b1;
    d = $urandom;
    push(3'd0, w(5), d);
    run({16'h0000, d, 8'h5C}, 4, 3'h2);
    push(3'd0, w(3), rf[8'h41]);
    run({16'h0000, 8'h41, 8'h38}, 4, 3'h2);
    // The load above lands after this note is made, so expect its source byte.
    push(3'd0, 8'h42, rf[8'h41]);
    run({16'h0000, 8'h42, 8'h39}, 4, 3'h2);
    s = rf[8'h43];
    push(3'd0, 8'h44, s);
    run({8'h00, 8'h44, 8'h43, 8'hE4}, 6, 3'h3);
    `CHK(rf[8'h43], s)
    push(3'd0, 8'h45, d);
    run({8'h00, d, 8'h45, 8'hE6}, 6, 3'h3);
    // pointer forms of the register moves.
    push(3'd0, 8'h49, rf[8'h48]);
    run({8'h00, 8'h49, 8'h47, 8'hE5}, 6, 3'h3);
    push(3'd0, 8'h48, d);
    run({8'h00, d, 8'h47, 8'hD6}, 6, 3'h3);
    push(3'd0, 8'h48, rf[8'h43]);
    run({8'h00, 8'h47, 8'h43, 8'hF5}, 6, 3'h3);
    push(3'd0, 8'h10, rf[w(2)]);
    run({8'h00, 8'hC0, 8'h26, 8'h97}, 6, 3'h3);
    push(3'd0, w(1), rf[8'h50]);
    run({16'h0000, 8'h16, 8'hC7}, 4, 3'h2);
    push(3'd0, 8'h50, rf[w(2)]);
    run({16'h0000, 8'h62, 8'hD7}, 4, 3'h2);
    ce_rand <= 1'b1;
    push(3'd0, w(7), rf[8'h05]);
    run({8'h00, 8'hB5, 8'h76, 8'h87}, 6, 3'h3);
    for (int dir = 0; dir < 2; dir++) begin
      b = $urandom;
      d = rf[8'h46];
      s = rf[w(4)];
      if (dir == 0) begin
        s[0] = d[b];
        push(3'd0, w(4), s);
      end else begin
        d[b] = s[0];
        push(3'd0, 8'h46, d);
      end
      run({8'h00, 8'h46, 4'h4, b, dir[0], 8'h47}, 6, 3'h3);
    end
    ce_rand <= 1'b0;
    @(posedge clock);
    ce <= 1'b1;
    // Earlier moves wrote some pair registers; give the pairs known values again.
    {rf[w(2)], rf[w(3)], rf[w(4)], rf[w(5)]} = 32'h1234FFF8;
    mem(8'hC3, 8'h82, 8'h00, 8'h00, 16'h1234, 10);
    mem(8'hC3, 8'h83, 8'h00, 8'h00, 16'h1234, 10);
    mem(8'hE7, 8'h84, 8'h10, 8'h00, 16'h0008, 12);
    mem(8'hA7, 8'h82, 8'h00, 8'h10, 16'h2234, 14);
    mem(8'hA7, 8'h80, 8'h78, 8'h56, 16'h5678, 14);
    mem(8'hA7, 8'h81, 8'h78, 8'h56, 16'h5678, 14);
    mem(8'hD3, 8'h93, 8'h00, 8'h00, 16'h1234, 10);
    mem(8'hD3, 8'h92, 8'h00, 8'h00, 16'h1234, 10);
    mem(8'hF7, 8'h95, 8'h20, 8'h00, 16'h0018, 12);
    mem(8'hB7, 8'h95, 8'h00, 8'h01, 16'h00F8, 14);
    run(32'h0000_0000, 1, 3'h1);
    @(posedge clock);
    rom_masked <= 1'b1;
    repeat (16) @(posedge clock);
    mem(8'hB7, 8'h90, 8'h00, 8'h20, 16'h2000, 14);
    repeat (4) @(posedge clock);
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule // tb_load_move_instruction_unit
`default_nettype wire

// [include/lmu_defines.vh]
`ifndef LMU_DEFINES_VH
`define LMU_DEFINES_VH

// Low-nibble opcodes of the compact forms; the high nibble names a working register.
`define OPC_NIB_IMM     4'hC
`define OPC_NIB_LOAD    4'h8
`define OPC_NIB_STORE   4'h9

// Full opcodes of the register-file moves.
`define OPC_LD_IND      8'hC7
`define OPC_ST_IND      8'hD7
`define OPC_MV_RR       8'hE4
`define OPC_MV_RIR      8'hE5
`define OPC_MV_RIM      8'hE6
`define OPC_MV_IRIM     8'hD6
`define OPC_MV_IRR      8'hF5
`define OPC_LD_IDX      8'h87
`define OPC_ST_IDX      8'h97
`define OPC_BIT         8'h47

// Opcodes of the memory transfers.
`define OPC_MEM_LD_IR   8'hC3
`define OPC_MEM_ST_IR   8'hD3
`define OPC_MEM_LD_XS   8'hE7
`define OPC_MEM_ST_XS   8'hF7
`define OPC_MEM_LD_XL   8'hA7
`define OPC_MEM_ST_XL   8'hB7

// Execution length in clock cycles for each group.
`define CYC_COMPACT     4'h4
`define CYC_THREE_BYTE  4'h6
`define CYC_MEM_IR      4'hA
`define CYC_MEM_XS      4'hC
`define CYC_MEM_XL      4'hE
`define CYC_BAD         4'h1

// Instruction length in bytes.
`define BYTES_BAD       3'h1
`define BYTES_TWO       3'h2
`define BYTES_THREE     3'h3
`define BYTES_FOUR      3'h4

// Step numbers inside an instruction.
`define STEP_RD0        4'h0
`define STEP_RD1        4'h1
`define STEP_RD2        4'h2
`define STEP_REG_WR     4'h2
`define STEP_MEM        4'h3
`define STEP_MEM_CAP    4'h5

// Register address whose high nibble selects the working-register bank.
`define WREG_ESC        4'hC
// Pair number that turns a long-offset form into a direct location.
`define PAIR_DIRECT     3'h0
// Bit-move second byte: direction flag position.
`define BIT_DIR         0

`endif

// [verilog/lmu_mem_addr.v]
`timescale 1ns/1ps
`default_nettype none
`include "lmu_defines.vh"

// Forms the memory address and the memory space of a memory transfer.
module lmu_mem_addr (
  input  wire [7:0]  opcode,
  input  wire [3:0]  pair_field,
  input  wire [7:0]  pair_hi,
  input  wire [7:0]  pair_lo,
  input  wire [7:0]  off_lo,
  input  wire [7:0]  off_hi,
  output reg  [15:0] addr,
  output wire        to_prog
);

  wire [15:0] pair_val = {pair_hi, pair_lo};
  wire        is_long  = (opcode == `OPC_MEM_LD_XL) || (opcode == `OPC_MEM_ST_XL);
  wire        is_short = (opcode == `OPC_MEM_LD_XS) || (opcode == `OPC_MEM_ST_XS);
  wire        direct   = is_long && (pair_field[3:1] == `PAIR_DIRECT);

  assign to_prog = ~pair_field[0];

  // Address select; sums wrap at sixteen bits.
  always @* begin
    if (direct) begin
      addr = {off_hi, off_lo};
    end else if (is_long) begin
      addr = pair_val + {off_hi, off_lo};
    end else if (is_short) begin
      addr = pair_val + {8'h00, off_lo};
    end else begin
      addr = pair_val;
    end
  end

endmodule // lmu_mem_addr
`default_nettype wire

// [verilog/load_move_instruction_unit.v]
`timescale 1ns/1ps
`default_nettype none
`include "lmu_defines.vh"

// Function
// - byte move copies, source left unchanged
// - no condition flag is ever written
// - compact rC, r8, r9 forms, four cycles
// - three-byte six-cycle moves including indexed
// - bit move, other destination bits kept
// - bit move byte fields and direction flag
// - memory transfer of one byte, either way
// - even pair program, odd pair data
// - pair indirect transfer, ten cycles
// - short offset transfer, twelve cycles
// - long offset transfer, fourteen cycles
// - long offset pair 0000/0001 means direct location
// - masked ROM blocks program memory writes
module load_move_instruction_unit (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        instr_valid,
  output wire        instr_ready,
  input  wire [7:0]  instr_b0,
  input  wire [7:0]  instr_b1,
  input  wire [7:0]  instr_b2,
  input  wire [7:0]  instr_b3,
  input  wire [3:0]  wr_base,
  output wire [7:0]  rf_raddr,
  input  wire [7:0]  rf_rdata,
  output wire        rf_we,
  output wire [7:0]  rf_waddr,
  output wire [7:0]  rf_wdata,
  output wire [15:0] mem_addr,
  output wire [7:0]  mem_wdata,
  input  wire [7:0]  mem_rdata,
  output wire        pm_rd,
  output wire        pm_wr,
  output wire        dm_rd,
  output wire        dm_wr,
  output wire        flags_we,
  input  wire        rom_masked,
  output wire        instr_done,
  output wire [2:0]  instr_bytes,
  output wire        bad_opcode,
  output wire        pm_write_blocked
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  // Working register n of the current bank.
  function [7:0] wreg;
    input [3:0] base;
    input [3:0] n;
    begin
      wreg = {base, n};
    end
  endfunction

  // Register operand, with the bank escape mapped onto working registers.
  function [7:0] rmap;
    input [3:0] base;
    input [7:0] a;
    begin
      rmap = (a[7:4] == `WREG_ESC) ? {base, a[3:0]} : a;
    end
  endfunction

  // Cycle count of an opcode.
  function [3:0] cyc_len;
    input [7:0] op;
    begin
      case (op)
        `OPC_LD_IND, `OPC_ST_IND: cyc_len = `CYC_COMPACT;
        `OPC_MV_RR, `OPC_MV_RIR, `OPC_MV_RIM, `OPC_MV_IRIM, `OPC_MV_IRR,
        `OPC_LD_IDX, `OPC_ST_IDX, `OPC_BIT: cyc_len = `CYC_THREE_BYTE;
        `OPC_MEM_LD_IR, `OPC_MEM_ST_IR: cyc_len = `CYC_MEM_IR;
        `OPC_MEM_LD_XS, `OPC_MEM_ST_XS: cyc_len = `CYC_MEM_XS;
        `OPC_MEM_LD_XL, `OPC_MEM_ST_XL: cyc_len = `CYC_MEM_XL;
        default: begin
          if ((op[3:0] == `OPC_NIB_IMM) || (op[3:0] == `OPC_NIB_LOAD) ||
              (op[3:0] == `OPC_NIB_STORE))
            cyc_len = `CYC_COMPACT;
          else
            cyc_len = `CYC_BAD;
        end
      endcase
    end
  endfunction

  // Byte count of an opcode.
  function [2:0] byte_len;
    input [7:0] op;
    begin
      case (cyc_len(op))
        `CYC_COMPACT, `CYC_MEM_IR: byte_len = `BYTES_TWO;
        `CYC_THREE_BYTE, `CYC_MEM_XS: byte_len = `BYTES_THREE;
        `CYC_MEM_XL: byte_len = `BYTES_FOUR;
        default: byte_len = `BYTES_BAD;
      endcase
    end
  endfunction

  // Byte with one bit replaced.
  function [7:0] put_bit;
    input [7:0] v;
    input [2:0] b;
    input       x;
    begin
      put_bit = v;
      put_bit[b] = x;
    end
  endfunction

  reg  [1:0]  state_r;
  reg  [3:0]  cnt_r;
  reg  [7:0]  op_r, b1_r, b2_r, b3_r;
  reg  [7:0]  t0_r, t1_r, t2_r;
  reg         rf_we_r;
  reg  [7:0]  rf_waddr_r, rf_wdata_r;
  reg  [15:0] mem_addr_r;
  reg  [7:0]  mem_wdata_r;
  reg         pm_rd_r, pm_wr_r, dm_rd_r, dm_wr_r, blocked_r;
  reg         rom_s1_r, rom_s2_r, rom_s3_r, rom_lock_r;
  reg  [7:0]  a0, a1, a2;
  reg         wr_en;
  reg  [7:0]  wr_addr, wr_data;

  wire [3:0]  hi   = b1_r[7:4];
  wire [3:0]  lo   = b1_r[3:0];
  wire [2:0]  bsel = b1_r[3:1];
  wire        busy = (state_r == ST_RUN);
  wire [3:0]  len  = cyc_len(op_r);
  wire        is_mem = (op_r == `OPC_MEM_LD_IR) || (op_r == `OPC_MEM_ST_IR) ||
                       (op_r == `OPC_MEM_LD_XS) || (op_r == `OPC_MEM_ST_XS) ||
                       (op_r == `OPC_MEM_LD_XL) || (op_r == `OPC_MEM_ST_XL);
  wire        mem_load = (op_r == `OPC_MEM_LD_IR) || (op_r == `OPC_MEM_LD_XS) ||
                         (op_r == `OPC_MEM_LD_XL);
  wire [15:0] gen_addr;
  wire        gen_prog;

  lmu_mem_addr u_addr (
    .opcode     (op_r),
    .pair_field (lo),
    .pair_hi    (t0_r),
    .pair_lo    (t1_r),
    .off_lo     (b2_r),
    .off_hi     (b3_r),
    .addr       (gen_addr),
    .to_prog    (gen_prog)
  );

  assign instr_ready      = (state_r == ST_IDLE);
  assign instr_done       = busy && (cnt_r == len - 4'h1);
  assign instr_bytes      = byte_len(op_r);
  assign bad_opcode       = instr_done && (len == `CYC_BAD);
  assign rf_raddr         = (cnt_r == `STEP_RD0) ? a0 : (cnt_r == `STEP_RD1) ? a1 : a2;
  assign rf_we            = rf_we_r;
  assign rf_waddr         = rf_waddr_r;
  assign rf_wdata         = rf_wdata_r;
  assign mem_addr         = mem_addr_r;
  assign mem_wdata        = mem_wdata_r;
  assign pm_rd            = pm_rd_r;
  assign pm_wr            = pm_wr_r;
  assign dm_rd            = dm_rd_r;
  assign dm_wr            = dm_wr_r;
  assign pm_write_blocked = blocked_r;
  assign flags_we         = 1'b0;

  // Read addresses for steps 0, 1 and 2.
  always @* begin
    a0 = 8'h00;
    a1 = 8'h00;
    a2 = wreg(wr_base, hi);
    case (op_r)
      `OPC_LD_IND: begin
        a0 = wreg(wr_base, lo);
        a1 = t0_r;
      end
      `OPC_ST_IND: begin
        a0 = wreg(wr_base, lo);
        a1 = wreg(wr_base, hi);
      end
      `OPC_MV_RR, `OPC_MV_IRIM: a0 = rmap(wr_base, b1_r);
      `OPC_MV_RIR: begin
        a0 = rmap(wr_base, b1_r);
        a1 = t0_r;
      end
      `OPC_MV_IRR: begin
        a0 = rmap(wr_base, b1_r);
        a1 = rmap(wr_base, b2_r);
      end
      `OPC_LD_IDX: begin
        a0 = wreg(wr_base, lo);
        a1 = b2_r + t0_r;
      end
      `OPC_ST_IDX: begin
        a0 = wreg(wr_base, hi);
        a1 = wreg(wr_base, lo);
      end
      `OPC_BIT: begin
        a0 = b1_r[`BIT_DIR] ? wreg(wr_base, hi) : rmap(wr_base, b2_r);
        a1 = b1_r[`BIT_DIR] ? rmap(wr_base, b2_r) : wreg(wr_base, hi);
      end
      `OPC_MEM_LD_IR, `OPC_MEM_ST_IR, `OPC_MEM_LD_XS, `OPC_MEM_ST_XS,
      `OPC_MEM_LD_XL, `OPC_MEM_ST_XL: begin
        a0 = wreg(wr_base, {lo[3:1], 1'b0});
        a1 = wreg(wr_base, {lo[3:1], 1'b1});
      end
      default: begin
        if (op_r[3:0] == `OPC_NIB_LOAD)
          a0 = rmap(wr_base, b1_r);
        else
          a0 = wreg(wr_base, op_r[7:4]);
      end
    endcase
  end

  // Register write target and value; only the destination is written.
  always @* begin
    wr_en   = busy && (cnt_r == `STEP_REG_WR) && !is_mem && (len != `CYC_BAD);
    wr_addr = 8'h00;
    wr_data = t0_r;
    case (op_r)
      `OPC_LD_IND: begin
        wr_addr = wreg(wr_base, hi);
        wr_data = t1_r;
      end
      `OPC_ST_IND: wr_addr = t1_r;
      `OPC_MV_RR: wr_addr = rmap(wr_base, b2_r);
      `OPC_MV_RIR: begin
        wr_addr = rmap(wr_base, b2_r);
        wr_data = t1_r;
      end
      `OPC_MV_RIM: begin
        wr_addr = rmap(wr_base, b1_r);
        wr_data = b2_r;
      end
      `OPC_MV_IRIM: begin
        wr_addr = t0_r;
        wr_data = b2_r;
      end
      `OPC_MV_IRR: wr_addr = t1_r;
      `OPC_LD_IDX: begin
        wr_addr = wreg(wr_base, hi);
        wr_data = t1_r;
      end
      `OPC_ST_IDX: wr_addr = b2_r + t1_r;
      `OPC_BIT: begin
        if (b1_r[`BIT_DIR]) begin
          wr_addr = rmap(wr_base, b2_r);
          wr_data = put_bit(t1_r, bsel, t0_r[0]);
        end else begin
          wr_addr = wreg(wr_base, hi);
          wr_data = put_bit(t1_r, 3'h0, t0_r[bsel]);
        end
      end
      default: begin
        if (op_r[3:0] == `OPC_NIB_IMM) begin
          wr_addr = wreg(wr_base, op_r[7:4]);
          wr_data = b1_r;
        end else if (op_r[3:0] == `OPC_NIB_LOAD)
          wr_addr = wreg(wr_base, op_r[7:4]);
        else
          wr_addr = rmap(wr_base, b1_r);
      end
    endcase
  end

  // Sequencer, operand latches and registered outputs.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 4'h0;
      op_r        <= 8'h00;
      b1_r        <= 8'h00;
      b2_r        <= 8'h00;
      b3_r        <= 8'h00;
      t0_r        <= 8'h00;
      t1_r        <= 8'h00;
      t2_r        <= 8'h00;
      rf_we_r     <= 1'b0;
      rf_waddr_r  <= 8'h00;
      rf_wdata_r  <= 8'h00;
      mem_addr_r  <= 16'h0000;
      mem_wdata_r <= 8'h00;
      pm_rd_r     <= 1'b0;
      pm_wr_r     <= 1'b0;
      dm_rd_r     <= 1'b0;
      dm_wr_r     <= 1'b0;
      blocked_r   <= 1'b0;
    end else if (ce) begin
      rf_we_r   <= 1'b0;
      pm_rd_r   <= 1'b0;
      pm_wr_r   <= 1'b0;
      dm_rd_r   <= 1'b0;
      dm_wr_r   <= 1'b0;
      blocked_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (instr_valid) begin
            op_r    <= instr_b0;
            b1_r    <= instr_b1;
            b2_r    <= instr_b2;
            b3_r    <= instr_b3;
            cnt_r   <= 4'h0;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_r == `STEP_RD0)
            t0_r <= rf_rdata;
          if (cnt_r == `STEP_RD1)
            t1_r <= rf_rdata;
          if (cnt_r == `STEP_RD2)
            t2_r <= rf_rdata;
          if (wr_en) begin
            rf_we_r    <= 1'b1;
            rf_waddr_r <= wr_addr;
            rf_wdata_r <= wr_data;
          end
          if (is_mem && (cnt_r == `STEP_MEM)) begin
            mem_addr_r  <= gen_addr;
            mem_wdata_r <= t2_r;
            pm_rd_r     <= mem_load && gen_prog;
            dm_rd_r     <= mem_load && !gen_prog;
            dm_wr_r     <= !mem_load && !gen_prog;
            pm_wr_r     <= !mem_load && gen_prog && !rom_lock_r;
            blocked_r   <= !mem_load && gen_prog && rom_lock_r;
          end
          if (is_mem && mem_load && (cnt_r == `STEP_MEM_CAP)) begin
            rf_we_r    <= 1'b1;
            rf_waddr_r <= wreg(wr_base, hi);
            rf_wdata_r <= mem_rdata;
          end
          if (instr_done)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r + 4'h1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Masked-ROM strap: three stages, accepted when the last two agree.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rom_s1_r   <= 1'b0;
      rom_s2_r   <= 1'b0;
      rom_s3_r   <= 1'b0;
      rom_lock_r <= 1'b0;
    end else if (ce) begin
      rom_s1_r <= rom_masked;
      rom_s2_r <= rom_s1_r;
      rom_s3_r <= rom_s2_r;
      if (rom_s2_r == rom_s3_r)
        rom_lock_r <= rom_s3_r;
    end
  end

endmodule // load_move_instruction_unit
`default_nettype wire
